// >>> hdl/pwm_pkg.sv
// constants shared by the sixteen-channel pwm output block
package pwm_pkg;
  localparam int          CHANNELS      = 16;
  localparam int          ADDR_W        = 8;
  localparam int          DUTY_W        = 8;
  localparam int          NIB_W         = 4;
  // register byte offsets, one aligned word each
  localparam logic [7:0]  OFF_DUTY_BASE = 8'h00;
  localparam logic [7:0]  OFF_DUTY_LAST = 8'h3c;
  localparam logic [7:0]  OFF_POL_LO    = 8'h40;
  localparam logic [7:0]  OFF_POL_HI    = 8'h44;
  localparam logic [7:0]  OFF_OE_LO     = 8'h48;
  localparam logic [7:0]  OFF_OE_HI     = 8'h4c;
  localparam logic [7:0]  OFF_DIR_ONE   = 8'h50;
  localparam logic [7:0]  OFF_DIR_TWO   = 8'h54;
  localparam logic [7:0]  OFF_LVL_ONE   = 8'h58;
  localparam logic [7:0]  OFF_LVL_TWO   = 8'h5c;
  localparam logic [7:0]  OFF_CLK_CTRL  = 8'h60;
  localparam logic [7:0]  OFF_SYS_CTRL  = 8'h64;
  localparam logic [7:0]  OFF_COUNT     = 8'h68;
  // word index field of the address
  localparam int          IDX_LSB       = 2;
  localparam int          IDX_MSB       = 5;
  // fields
  localparam int          BIT_CLK_GATE  = 0;
  localparam int          BIT_CLK_PICK  = 1;
  localparam int          BIT_HIGH_WIN  = 0;
  // reset values, last count nibble and sync pattern
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [3:0]  NIB_LAST      = 4'hf;
  localparam logic [1:0]  SYNC_ONES     = 2'b11;
endpackage

// >>> hdl/sixteen_channel_pwm.sv
// sixteen-channel pwm output block with apb register slave and pin muxing
//
// Decided for this implementation: the register offsets and the APB register port.

module sixteen_channel_pwm (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // standby requests from chip mode logic, same clock
  input  wire logic        softStandby,
  input  wire logic        hwStandby,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared pins
  output logic      [15:0] pinOut,
  output logic      [15:0] pinOe
);

  localparam int CH = pwm_pkg::CHANNELS;

  // reset release through two flip-flops
  logic [1:0] rstSync;
  logic       rstLocal_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= '0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  // take the second flop directly: a decoded reset could glitch into the async pins
  assign rstLocal_n = rstSync[1];

  // registers
  logic [7:0]  duty       [CH];
  logic [7:0]  next_duty  [CH];
  logic [15:0] polarity;
  logic [15:0] next_polarity;
  logic [15:0] outSelect;
  logic [15:0] next_outSelect;
  logic [15:0] direction;
  logic [15:0] next_direction;
  logic [15:0] portLevel;
  logic [15:0] next_portLevel;
  logic        clockGate;
  logic        next_clockGate;
  logic        clockChoice;
  logic        next_clockChoice;
  logic        highWindow;
  logic        next_highWindow;

  // bus answer
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // time base
  logic [7:0]  count;
  logic [7:0]  next_count;
  logic        divPhase;
  logic        next_divPhase;
  logic        tick;
  logic [7:0]  activeDuty      [CH];
  logic [7:0]  next_activeDuty [CH];
  logic [15:0] next_pinOut;
  logic [15:0] next_pinOe;

  // access phase strobes; the answer comes one cycle into the access phase
  logic        accessNow;
  logic        isDuty;
  logic        dutyBlocked;
  logic [3:0]  dutyIdx;

  assign accessNow   = psel && penable && !pready;
  assign isDuty      = (paddr <= pwm_pkg::OFF_DUTY_LAST) && (paddr[1:0] == 2'b00);
  assign dutyIdx     = paddr[pwm_pkg::IDX_MSB:pwm_pkg::IDX_LSB];
  assign dutyBlocked = isDuty && highWindow;

  // extra pulse placement: basic pulse k takes one when the bit-reversed
  // complement of k is below the lower nibble, spreading them evenly
  function automatic logic extraHere(input logic [3:0] pulseNo, input logic [3:0] lower);
    logic [3:0] inv;
    logic [3:0] rev;
    inv = ~pulseNo;
    rev = {inv[0], inv[1], inv[2], inv[3]};
    return rev < lower;
  endfunction

  function automatic logic [15:0] byteWord(input logic [7:0] lo, input logic [7:0] hi, input logic pickHi,
                                           input logic [7:0] data);
    return pickHi ? {data, lo} : {hi, data};
  endfunction

  // register file next values
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      next_duty[i] = duty[i];
    end
    next_polarity    = polarity;
    next_outSelect   = outSelect;
    next_direction   = direction;
    next_portLevel   = portLevel;
    next_clockGate   = clockGate;
    next_clockChoice = clockChoice;
    next_highWindow  = highWindow;
    if (accessNow && pwrite) begin
      if (isDuty) begin
        if (!highWindow) begin
          next_duty[dutyIdx] = pwdata[7:0];
        end
      end else begin
        case (paddr)
          pwm_pkg::OFF_POL_LO: begin
            next_polarity = byteWord(polarity[7:0], polarity[15:8], 1'b0, pwdata[7:0]);
          end
          pwm_pkg::OFF_POL_HI: begin
            next_polarity = byteWord(polarity[7:0], polarity[15:8], 1'b1, pwdata[7:0]);
          end
          pwm_pkg::OFF_OE_LO: begin
            next_outSelect = byteWord(outSelect[7:0], outSelect[15:8], 1'b0, pwdata[7:0]);
          end
          pwm_pkg::OFF_OE_HI: begin
            next_outSelect = byteWord(outSelect[7:0], outSelect[15:8], 1'b1, pwdata[7:0]);
          end
          pwm_pkg::OFF_DIR_ONE: begin
            next_direction = byteWord(direction[7:0], direction[15:8], 1'b0, pwdata[7:0]);
          end
          pwm_pkg::OFF_DIR_TWO: begin
            next_direction = byteWord(direction[7:0], direction[15:8], 1'b1, pwdata[7:0]);
          end
          pwm_pkg::OFF_LVL_ONE: begin
            next_portLevel = byteWord(portLevel[7:0], portLevel[15:8], 1'b0, pwdata[7:0]);
          end
          pwm_pkg::OFF_LVL_TWO: begin
            next_portLevel = byteWord(portLevel[7:0], portLevel[15:8], 1'b1, pwdata[7:0]);
          end
          pwm_pkg::OFF_CLK_CTRL: begin
            next_clockGate   = pwdata[pwm_pkg::BIT_CLK_GATE];
            next_clockChoice = pwdata[pwm_pkg::BIT_CLK_PICK];
          end
          pwm_pkg::OFF_SYS_CTRL: begin
            next_highWindow = pwdata[pwm_pkg::BIT_HIGH_WIN];
          end
          default: ;
        endcase
      end
    end
    // standby clears after any write in the same cycle
    if (softStandby || hwStandby) begin
      for (int i = 0; i < CH; i++) begin
        next_duty[i] = pwm_pkg::RST_BYTE;
      end
    end
    if (hwStandby) begin
      next_polarity  = {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
      next_outSelect = {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      for (int i = 0; i < CH; i++) begin
        duty[i] <= pwm_pkg::RST_BYTE;
      end
      polarity    <= {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
      outSelect   <= {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
      direction   <= {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
      portLevel   <= {pwm_pkg::RST_BYTE, pwm_pkg::RST_BYTE};
      clockGate   <= 1'b0;
      clockChoice <= 1'b0;
      highWindow  <= 1'b0;
    end else begin
      for (int i = 0; i < CH; i++) begin
        duty[i] <= next_duty[i];
      end
      polarity    <= next_polarity;
      outSelect   <= next_outSelect;
      direction   <= next_direction;
      portLevel   <= next_portLevel;
      clockGate   <= next_clockGate;
      clockChoice <= next_clockChoice;
      highWindow  <= next_highWindow;
    end
  end

  // bus answer: read data, ready and error are all registered
  always_comb begin
    next_prdata  = pwm_pkg::RST_WORD;
    next_pready  = accessNow;
    next_pslverr = 1'b0;
    if (accessNow) begin
      if (isDuty) begin
        next_pslverr = dutyBlocked;
        if (!pwrite && !dutyBlocked) begin
          next_prdata[7:0] = duty[dutyIdx];
        end
      end else begin
        case (paddr)
          pwm_pkg::OFF_POL_LO: begin
            next_prdata[7:0] = polarity[7:0];
          end
          pwm_pkg::OFF_POL_HI: begin
            next_prdata[7:0] = polarity[15:8];
          end
          pwm_pkg::OFF_OE_LO: begin
            next_prdata[7:0] = outSelect[7:0];
          end
          pwm_pkg::OFF_OE_HI: begin
            next_prdata[7:0] = outSelect[15:8];
          end
          // direction registers are write-only and read back as zero
          pwm_pkg::OFF_DIR_ONE: begin
            next_prdata[7:0] = pwm_pkg::RST_BYTE;
          end
          pwm_pkg::OFF_DIR_TWO: begin
            next_prdata[7:0] = pwm_pkg::RST_BYTE;
          end
          pwm_pkg::OFF_LVL_ONE: begin
            next_prdata[7:0] = portLevel[7:0];
          end
          pwm_pkg::OFF_LVL_TWO: begin
            next_prdata[7:0] = portLevel[15:8];
          end
          pwm_pkg::OFF_CLK_CTRL: begin
            next_prdata[pwm_pkg::BIT_CLK_GATE] = clockGate;
            next_prdata[pwm_pkg::BIT_CLK_PICK] = clockChoice;
          end
          pwm_pkg::OFF_SYS_CTRL: begin
            next_prdata[pwm_pkg::BIT_HIGH_WIN] = highWindow;
          end
          pwm_pkg::OFF_COUNT: begin
            next_prdata[7:0] = count;
          end
          default: begin
            next_pslverr = 1'b1;
          end
        endcase
      end
      if (pwrite) begin
        next_prdata = pwm_pkg::RST_WORD;
      end
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      prdata  <= pwm_pkg::RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // count clock: the peripheral clock is clk, so its half rate is every
  // second edge; a stopped clock freezes the count where it stands
  assign tick = clockGate && (!clockChoice || divPhase);

  // shared time base
  always_comb begin
    next_divPhase = !divPhase;
    next_count    = count;
    if (tick) begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      divPhase <= 1'b0;
      count    <= pwm_pkg::RST_BYTE;
    end else begin
      divPhase <= next_divPhase;
      count    <= next_count;
    end
  end

  // working copy of each duty value, swapped at a basic period boundary
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      next_activeDuty[i] = activeDuty[i];
      // a stopped clock has no pulse to cut short, so follow at once
      if ((tick && count[3:0] == pwm_pkg::NIB_LAST) || !clockGate) begin
        next_activeDuty[i] = duty[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      for (int i = 0; i < CH; i++) begin
        activeDuty[i] <= pwm_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        activeDuty[i] <= next_activeDuty[i];
      end
    end
  end

  // pin drivers, one clock behind the count they follow
  always_comb begin
    logic [3:0] upper;
    logic [3:0] lower;
    logic       wave;
    upper = '0;
    lower = '0;
    wave  = 1'b0;
    for (int i = 0; i < CH; i++) begin
      upper = activeDuty[i][7:4];
      lower = activeDuty[i][3:0];
      // basic pulse on positions 0..upper-1 of each 16-tick period
      wave = (count[3:0] < upper);
      // extra tick in the last position, just ahead of the next rise
      if (count[3:0] == pwm_pkg::NIB_LAST && extraHere(count[7:4], lower)) begin
        wave = 1'b1;
      end
      // with upper nibble 15 and no extra the last tick stays low: 255/256 at most
      next_pinOe[i] = direction[i];
      if (outSelect[i]) begin
        next_pinOut[i] = wave ^ polarity[i];
      end else begin
        next_pinOut[i] = portLevel[i];
      end
      // an input pin carries no level, so nothing stray shows while released
      if (!direction[i]) begin
        next_pinOut[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

endmodule

// >>> bench/pwm_asserts.sv
// concurrent checks on the ports of the pwm block
module pwm_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_answer; s_access |=> s_answer; endproperty
  a_answer: assert property (p_answer)
    else $error("access phase not answered after one wait state");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error flag outside the answer cycle");
  property p_quiet_data; !pready |-> prdata == 32'h0; endproperty
  a_quiet_data: assert property (p_quiet_data)
    else $error("read data outside the answer cycle");
  property p_byte_wide; pready |-> prdata[31:8] == 24'h0; endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("read data above bit 7");
  property p_dir_read;
    pready && !pwrite && (paddr == pwm_pkg::OFF_DIR_ONE || paddr == pwm_pkg::OFF_DIR_TWO)
      |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction register not read as zero");
  property p_unmapped; pready && paddr >= 8'h6c |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address answered without error");
  property p_input_low; (pinOut & ~pinOe) == 16'h0; endproperty
  a_input_low: assert property (p_input_low)
    else $error("pin level driven while in input mode");
  property p_oe_follows_write; $changed(pinOe) |-> $past(psel && penable && pwrite, 2); endproperty
  a_oe_follows_write: assert property (p_oe_follows_write)
    else $error("pin enables changed without a write");
endmodule

bind sixteen_channel_pwm pwm_asserts i_pwm_asserts (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pinOut(pinOut), .pinOe(pinOe));

// >>> bench/pin_load.sv
// external load model: tallies driven-high cycles on every pin
module pin_load (
  // clock
  input wire logic        clk,
  // pins
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [16] = '{default: 0};
  // an undriven pin reads low through the load's pull-down
  always @(posedge clk) foreach (cnt[i]) cnt[i] <= cnt[i] + int'(pinOut[i] & pinOe[i]);
endmodule

// >>> bench/tb_sixteen_channel_pwm.sv
// self-checking bench for the sixteen-channel pwm block
module tb_sixteen_channel_pwm;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, softStandby, hwStandby, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pinOut, pinOe;
  int          err_total, n_tests, dir, oe, pol, lvl;
  int          duty [16];
  int          b0 [16];

  sixteen_channel_pwm i_sixteen_channel_pwm (.clk(clk), .rst_n(rst_n), .softStandby(softStandby),
    .hwStandby(hwStandby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinOut(pinOut), .pinOe(pinOe));
  pin_load i_pin_load (.clk(clk), .pinOut(pinOut), .pinOe(pinOe));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task xfer(bit w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rdc(logic [7:0] a, logic [31:0] ex, logic ee);
    xfer(0, a, 0);
    chk("rdata", ex, rd);
    chk("slverr", ee, e);
  endtask

  task pair(logic [7:0] lo, logic [7:0] hi, int v);
    xfer(1, lo, v & 255);
    xfer(1, hi, (v >> 8) & 255);
  endtask

  function int exp_hi(int i, int m);
    if (!dir[i]) return 0;
    if (!oe[i]) return lvl[i] * 256 * m;
    return pol[i] ? 256 * m - duty[i] * m : duty[i] * m;
  endfunction

  // a whole number of conversion periods makes the tally independent of phase
  task meas(int m);
    @(posedge clk);
    foreach (b0[i]) b0[i] = i_pin_load.cnt[i];
    repeat (256 * m) @(posedge clk);
    for (int i = 0; i < 16; i++) chk("highs", exp_hi(i, m), i_pin_load.cnt[i] - b0[i]);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    rst_n = 0; softStandby = 0; hwStandby = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    err_total = 0; n_tests = 0;
    void'($urandom(32'h87bd));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 22; i++) rdc(8'(4 * i), 0, 0);
    rdc(8'h6c, 0, 1);
    foreach (duty[i]) begin
      duty[i] = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(255);
      xfer(1, 8'(4 * i), duty[i]);
    end
    foreach (duty[i]) rdc(8'(4 * i), duty[i], 0);
    xfer(1, pwm_pkg::OFF_SYS_CTRL, 1);
    xfer(1, 8'h08, 8'h5a);
    chk("slverr", 1, e);
    rdc(8'h08, 0, 1);
    xfer(1, pwm_pkg::OFF_SYS_CTRL, 0);
    rdc(8'h08, duty[2], 0);
    dir = 16'heff7;
    oe = 16'hfbdf;
    pol = $urandom_range(16'hffff);
    lvl = $urandom_range(16'hffff);
    pair(pwm_pkg::OFF_DIR_ONE, pwm_pkg::OFF_DIR_TWO, dir);
    pair(pwm_pkg::OFF_OE_LO, pwm_pkg::OFF_OE_HI, oe);
    pair(pwm_pkg::OFF_POL_LO, pwm_pkg::OFF_POL_HI, pol);
    pair(pwm_pkg::OFF_LVL_ONE, pwm_pkg::OFF_LVL_TWO, lvl);
    rdc(pwm_pkg::OFF_POL_HI, (pol >> 8) & 255, 0);
    rdc(pwm_pkg::OFF_OE_LO, oe & 255, 0);
    xfer(1, pwm_pkg::OFF_CLK_CTRL, 1);
    repeat (600) @(posedge clk);
    chk("pinOe", dir, pinOe);
    meas(1);
    xfer(1, pwm_pkg::OFF_CLK_CTRL, 3);
    repeat (1100) @(posedge clk);
    meas(2);
    @(posedge clk) softStandby <= 1;
    @(posedge clk) softStandby <= 0;
    foreach (duty[i]) duty[i] = 0;
    rdc(8'h04, 0, 0);
    rdc(pwm_pkg::OFF_POL_LO, pol & 255, 0);
    repeat (64) @(posedge clk);
    meas(2);
    @(posedge clk) hwStandby <= 1;
    @(posedge clk) hwStandby <= 0;
    rdc(pwm_pkg::OFF_POL_HI, 0, 0);
    rdc(pwm_pkg::OFF_OE_HI, 0, 0);
    repeat (3) @(posedge clk);
    chk("pinOe", dir, pinOe);
    complete_run();
  end
endmodule
